// file: design/spc_brg.sv
`timescale 1ns/1ps
module spc_brg (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  spc_brg_if.gen b
);
  import spc_pkg::*;
  logic [7:0] cnt;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= BAUD_RST;
    end else if (b.restart || cnt == 8'h00) begin
      cnt <= b.div;
    end else begin
      cnt <= cnt - 8'h01;
    end
  end

  assign b.tick = (cnt == 8'h00) & ~b.restart;

  property p_restart;
    @(posedge mclk_i) disable iff (sys_rst_i)
    b.restart |=> cnt == $past(b.div);
  endproperty
  a_restart: assert property (p_restart)
    else $error("baud timer not reloaded on restart");

  property p_gap;
    @(posedge mclk_i) disable iff (sys_rst_i)
    b.tick && b.div == 8'h01 && !b.restart
      ##1 !b.restart |-> !b.tick;
  endproperty
  a_gap: assert property (p_gap)
    else $error("baud tick spacing wrong");
endmodule : spc_brg

// file: design/spc_if.sv
`timescale 1ns/1ps
interface spc_fifo_if;
  import spc_pkg::*;
  logic push;
  logic pop;
  logic flush;
  logic [ENTRY_W-1:0] din;
  logic [ENTRY_W-1:0] q;
  logic [1:0] cnt;
  modport owner (output push, pop, flush, din, input q, cnt);
  modport mem (input push, pop, flush, din, output q, cnt);
endinterface : spc_fifo_if

interface spc_brg_if;
  logic restart;
  logic [7:0] div;
  logic tick;
  modport owner (output restart, div, input tick);
  modport gen (input restart, div, output tick);
endinterface : spc_brg_if

// file: design/spc_pkg.sv
package spc_pkg;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int ENTRY_W = 10;
  localparam logic [7:0] OFF_RXDATA = 8'h00;
  localparam logic [7:0] OFF_RXCTL = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_TXCTL = 8'h0C;
  localparam logic [7:0] OFF_TXDATA = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_BAUD_SPEED_SELECT = 2;
  localparam int TX_EMPTY = 1;
  localparam int TX_NINTH = 0;
  localparam int RX_PEN = 7;
  localparam int RX_NINE = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RX_ADDRESS_DETECT_ENABLE = 3;
  localparam int RX_FRAMING_ERROR_FLAG = 2;
  localparam int RX_OVERRUN_ERROR_FLAG = 1;
  localparam int RX_NINTH = 0;
  localparam int ST_PEND = 0;
  localparam int ST_TXFULL = 1;
  localparam logic [7:0] RXCTL_RST = 8'h00;
  localparam logic [7:0] TXCTL_RST = 8'h02;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] TXDATA_RST = 8'h00;
  localparam logic [6:0] MUL_LO = 7'h40;
  localparam logic [6:0] MUL_HI = 7'h10;
  localparam logic [6:0] MUL_SYNC = 7'h04;
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  localparam logic [3:0] FRAME_EXTRA = 4'h2;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } spc_rx_state_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } spc_tx_state_t;
endpackage : spc_pkg

// file: design/spc_rx_fifo.sv
`timescale 1ns/1ps
module spc_rx_fifo (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  spc_fifo_if.mem f
);
  import spc_pkg::*;
  logic [ENTRY_W-1:0] e1;

  // Head entry is the registered read port
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      f.cnt <= 2'h0;
      f.q <= '0;
      e1 <= '0;
    end else if (f.flush) begin
      f.cnt <= 2'h0;
    end else if (f.pop && f.cnt != 2'h0) begin
      f.q <= (f.cnt == FIFO_DEPTH) ? e1 : f.din;
      if (f.push && f.cnt == FIFO_DEPTH) begin
        e1 <= f.din;
      end
      if (!f.push) begin
        f.cnt <= f.cnt - 2'h1;
      end
    end else if (f.push && f.cnt != FIFO_DEPTH) begin
      if (f.cnt == 2'h0) begin
        f.q <= f.din;
      end else begin
        e1 <= f.din;
      end
      f.cnt <= f.cnt + 2'h1;
    end
  end

  property p_depth;
    @(posedge mclk_i) disable iff (sys_rst_i)
    f.cnt == FIFO_DEPTH && !f.pop && !f.flush
      |=> f.cnt == FIFO_DEPTH && f.q == $past(f.q);
  endproperty
  a_depth: assert property (p_depth)
    else $error("fifo grew past two entries");

  property p_first;
    @(posedge mclk_i) disable iff (sys_rst_i)
    f.cnt == 2'h0 && f.push && !f.flush |=> f.q == $past(f.din);
  endproperty
  a_first: assert property (p_first)
    else $error("first entry not at head");
endmodule : spc_rx_fifo

// file: design/spc_top.sv
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Synchronous: clock source bit set means master clock, clear means slave.
// - Transmit nine-bit select sends nine data bits, else eight.
// - Mode bit set selects synchronous, clear selects asynchronous operation.
// - Speed select picks x16 or x64 timing, asynchronous only.
// - Transmit shift empty bit reads one while shifter idle; resets to one.
// - Ninth transmit bit goes out as ninth character bit.
// - Synchronous receive enables override transmit enable.
// - Port enable activates pins; clear holds the port in reset.
// - Receive nine-bit select takes nine data bits, else eight.
// - Single receive starts one master reception, cleared by hardware after.
// - Continuous receive enables receiver; overrides single receive in sync.
// - Address detect, async nine-bit only, loads only characters with ninth bit set.
// - Framing error bit shows head character's stop-bit failure.
// - Overrun flag cleared when software clears continuous receive.
// - Port drives or releases its pins as operation needs.
// - Baud generator is an 8-bit free-running reload timer.
// - Async bit rate is clock over 64 or 16 times divisor plus one.
// - Sync bit rate is clock over 4 times divisor plus one.
// - Writing the divisor restarts the baud timer at once.
// - Two-entry receive FIFO; third character sets overrun, stops reception.
// - Receive pending while receiver enabled and a character unread.
// - Start edge rechecked at half bit; false start dropped silently.
module spc_top (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [spc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [spc_pkg::DAT_W-1:0] wb_dat_i,
  output logic [spc_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxdt_i,
  output logic rxdt_o,
  output logic rxdt_oe_n_o,
  input wire logic txck_i,
  output logic txck_o,
  output logic txck_oe_n_o,
  output logic receive_pending_o
);
  import spc_pkg::*;

  spc_fifo_if fif ();
  spc_brg_if brg ();

  logic port_enable, rx_nine, single_receive_enable, continuous_receive_enable, address_detect_enable, overrun_error_flag;
  logic clock_source_select, tx_nine, transmit_enable_bit, sync, baud_speed_select, tx_ninth, tx_full;
  logic [7:0] baud, txdata, rdata;
  logic acc, wr, rd;
  logic dt_s1, dt_s2, dt_d, ck_s1, ck_s2, ck_d;
  logic srst, master, slave, rx_sync_en, rx_en, tx_allow;
  logic [6:0] mult, half;
  logic [5:0] ph, rph;
  logic ph_last, bit_end, mid, ck_rise, ck_fall;
  logic r_half, r_end, samp_s, falling;
  spc_tx_state_t tx_st;
  spc_rx_state_t rx_st;
  logic [10:0] transmit_shift_register;
  logic [3:0] tcnt, rbits, rx_len;
  logic t_step, t_load;
  logic [8:0] receive_shift_register, rx_char;
  logic r_done, r_framing_error_flag, keep, ovf, single_receive_enable_done, continuous_receive_enable_fall;

  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign srst = ~port_enable;
  assign master = sync & clock_source_select;
  assign slave = sync & ~clock_source_select;
  assign rx_sync_en = sync & (continuous_receive_enable | (single_receive_enable & clock_source_select));
  assign rx_en = sync ? rx_sync_en : continuous_receive_enable;
  assign tx_allow = transmit_enable_bit & ~rx_sync_en;
  assign continuous_receive_enable_fall = wr & (wb_adr_i == OFF_RXCTL) & continuous_receive_enable
    & ~wb_dat_i[RX_CONTINUOUS_RECEIVE_ENABLE];

  // Wishbone ack and read data
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      if (rd) begin
        wb_dat_o <= {24'h000000, rdata};
      end
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (wb_adr_i == OFF_RXDATA) begin
      rdata = fif.q[7:0];
    end else if (wb_adr_i == OFF_RXCTL) begin
      rdata = {port_enable, rx_nine, single_receive_enable, continuous_receive_enable, address_detect_enable,
        fif.q[9] & (fif.cnt != 2'h0), overrun_error_flag, fif.q[8]};
    end else if (wb_adr_i == OFF_BAUD) begin
      rdata = baud;
    end else if (wb_adr_i == OFF_TXCTL) begin
      rdata = {clock_source_select, tx_nine, transmit_enable_bit, sync, 1'b0, baud_speed_select,
        tx_st == TX_IDLE, tx_ninth};
    end else if (wb_adr_i == OFF_STAT) begin
      rdata = {6'h00, tx_full, receive_pending_o};
    end
  end

  // Control register writes
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_enable <= RXCTL_RST[RX_PEN];
      rx_nine <= RXCTL_RST[RX_NINE];
      single_receive_enable <= RXCTL_RST[RX_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable <= RXCTL_RST[RX_CONTINUOUS_RECEIVE_ENABLE];
      address_detect_enable <= RXCTL_RST[RX_ADDRESS_DETECT_ENABLE];
    end else if (wr && wb_adr_i == OFF_RXCTL) begin
      port_enable <= wb_dat_i[RX_PEN];
      rx_nine <= wb_dat_i[RX_NINE];
      single_receive_enable <= wb_dat_i[RX_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable <= wb_dat_i[RX_CONTINUOUS_RECEIVE_ENABLE];
      address_detect_enable <= wb_dat_i[RX_ADDRESS_DETECT_ENABLE];
    end else if (single_receive_enable_done) begin
      single_receive_enable <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clock_source_select <= TXCTL_RST[TX_CLOCK_SOURCE_SELECT];
      tx_nine <= TXCTL_RST[TX_NINE];
      transmit_enable_bit <= TXCTL_RST[TX_EN];
      sync <= TXCTL_RST[TX_SYNC];
      baud_speed_select <= TXCTL_RST[TX_BAUD_SPEED_SELECT];
      tx_ninth <= TXCTL_RST[TX_NINTH];
    end else if (wr && wb_adr_i == OFF_TXCTL) begin
      clock_source_select <= wb_dat_i[TX_CLOCK_SOURCE_SELECT];
      tx_nine <= wb_dat_i[TX_NINE];
      transmit_enable_bit <= wb_dat_i[TX_EN];
      sync <= wb_dat_i[TX_SYNC];
      baud_speed_select <= wb_dat_i[TX_BAUD_SPEED_SELECT];
      tx_ninth <= wb_dat_i[TX_NINTH];
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      baud <= BAUD_RST;
    end else if (wr && wb_adr_i == OFF_BAUD) begin
      baud <= wb_dat_i[7:0];
    end
  end

  // Transmit holding register
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      txdata <= TXDATA_RST;
      tx_full <= 1'b0;
    end else if (wr && wb_adr_i == OFF_TXDATA) begin
      txdata <= wb_dat_i[7:0];
      tx_full <= 1'b1;
    end else if (srst || t_load) begin
      tx_full <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      overrun_error_flag <= 1'b0;
    end else if (srst) begin
      overrun_error_flag <= 1'b0;
    end else if (ovf) begin
      overrun_error_flag <= 1'b1;
    end else if (continuous_receive_enable_fall) begin
      overrun_error_flag <= 1'b0;
    end
  end

  // Pin synchronisers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {dt_s1, dt_s2, dt_d} <= 3'h7;
      {ck_s1, ck_s2, ck_d} <= 3'h7;
    end else begin
      {dt_s1, dt_s2, dt_d} <= {rxdt_i, dt_s1, dt_s2};
      {ck_s1, ck_s2, ck_d} <= {txck_i, ck_s1, ck_s2};
    end
  end
  assign ck_rise = ck_s2 & ~ck_d;
  assign ck_fall = ~ck_s2 & ck_d;
  assign falling = dt_d & ~dt_s2;

  assign brg.restart = (wr && wb_adr_i == OFF_BAUD) || srst;
  assign brg.div = (wr && wb_adr_i == OFF_BAUD) ? wb_dat_i[7:0] : baud;
  spc_brg u_brg (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .b(brg)
  );

  assign mult = sync ? MUL_SYNC : (baud_speed_select ? MUL_HI : MUL_LO);
  assign half = {1'b0, mult[6:1]};
  assign ph_last = {1'b0, ph} == mult - 7'h01;
  assign bit_end = brg.tick & ph_last;
  assign mid = brg.tick & ({1'b0, ph} == half - 7'h01);

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ph <= 6'h00;
    end else if (brg.restart) begin
      ph <= 6'h00;
    end else if (brg.tick) begin
      ph <= ph_last ? 6'h00 : ph + 6'h01;
    end
  end

  // Transmit shifter
  assign t_step = slave ? ck_fall : bit_end;
  assign t_load = tx_st == TX_IDLE && tx_full && tx_allow
    && (slave || bit_end);

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_st <= TX_IDLE;
      transmit_shift_register <= '1;
      tcnt <= 4'h0;
    end else if (srst || !tx_allow) begin
      tx_st <= TX_IDLE;
      transmit_shift_register <= '1;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          if (t_load) begin
            tx_st <= TX_SHIFT;
            if (sync) begin
              transmit_shift_register <= tx_nine ? {2'h3, tx_ninth, txdata}
                : {3'h7, txdata};
            end else begin
              transmit_shift_register <= tx_nine ? {1'b1, tx_ninth, txdata, 1'b0}
                : {2'h3, txdata, 1'b0};
            end
            tcnt <= (tx_nine ? BITS9 : BITS8)
              + (sync ? 4'h0 : FRAME_EXTRA);
          end
        end
        TX_SHIFT: begin
          if (t_step) begin
            transmit_shift_register <= {1'b1, transmit_shift_register[10:1]};
            tcnt <= tcnt - 4'h1;
            if (tcnt == 4'h1) begin
              tx_st <= TX_IDLE;
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // Receive engine
  // receive length
  assign rx_len = rx_nine ? BITS9 : BITS8;
  assign r_half = brg.tick & ({1'b0, rph} == half - 7'h01);
  assign r_end = brg.tick & ({1'b0, rph} == mult - 7'h01);
  assign samp_s = master ? mid : ck_rise;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_st <= RX_IDLE;
      rph <= 6'h00;
      rbits <= 4'h0;
      receive_shift_register <= 9'h000;
      r_done <= 1'b0;
      r_framing_error_flag <= 1'b0;
    end else if (srst || !rx_en) begin
      rx_st <= RX_IDLE;
      r_done <= 1'b0;
    end else begin
      r_done <= 1'b0;
      if (brg.tick) begin
        rph <= r_end ? 6'h00 : rph + 6'h01;
      end
      case (rx_st)
        RX_IDLE: begin
          rbits <= 4'h0;
          rph <= 6'h00;
          if (!overrun_error_flag && !sync && falling) begin
            rx_st <= RX_START;
          end else if (!overrun_error_flag && sync && (slave || bit_end)) begin
            rx_st <= RX_DATA;
          end
        end
        RX_START: begin
          if (r_half) begin
            rph <= 6'h00;
            rx_st <= dt_s2 ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (sync ? samp_s : r_end) begin
            receive_shift_register <= {dt_s2, receive_shift_register[8:1]};
            rbits <= rbits + 4'h1;
            if (rbits == rx_len - 4'h1) begin
              rx_st <= sync ? RX_IDLE : RX_STOP;
              r_done <= sync;
              r_framing_error_flag <= 1'b0;
            end
          end
        end
        RX_STOP: begin
          if (r_end) begin
            r_framing_error_flag <= ~dt_s2;
            r_done <= 1'b1;
            rx_st <= RX_IDLE;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  assign rx_char = rx_nine ? receive_shift_register : {1'b0, receive_shift_register[8:1]};
  assign keep = sync | ~rx_nine | ~address_detect_enable | rx_char[8];
  assign ovf = r_done & keep & (fif.cnt == FIFO_DEPTH) & ~fif.pop;
  assign single_receive_enable_done = r_done & master;
  assign fif.push = r_done & keep & ~ovf & ~overrun_error_flag;
  assign fif.din = {r_framing_error_flag, rx_char};
  assign fif.pop = rd && wb_adr_i == OFF_RXDATA;
  assign fif.flush = srst;

  spc_rx_fifo u_fifo (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .f(fif)
  );

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      receive_pending_o <= 1'b0;
    end else begin
      receive_pending_o <= rx_en & (fif.cnt != 2'h0);
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {rxdt_o, rxdt_oe_n_o, txck_o, txck_oe_n_o} <= 4'hF;
    end else if (srst) begin
      {rxdt_o, rxdt_oe_n_o, txck_o, txck_oe_n_o} <= 4'hF;
    end else if (!sync) begin
      // async: data out on clock pin
      {rxdt_o, rxdt_oe_n_o} <= 2'h3;
      txck_o <= transmit_shift_register[0];
      txck_oe_n_o <= 1'b0;
    end else begin
      rxdt_o <= transmit_shift_register[0];
      rxdt_oe_n_o <= tx_st != TX_SHIFT;
      txck_oe_n_o <= ~clock_source_select;
      txck_o <= (tx_st != TX_SHIFT && rx_st != RX_DATA)
        || ({1'b0, ph} >= half);
    end
  end

  property p_overrun_error_flag_clr;
    @(posedge mclk_i) disable iff (sys_rst_i)
    continuous_receive_enable_fall && !ovf |=> !overrun_error_flag;
  endproperty
  a_overrun_error_flag_clr: assert property (p_overrun_error_flag_clr)
    else $error("overrun not cleared by receive disable");

  property p_ovf;
    @(posedge mclk_i) disable iff (sys_rst_i)
    ovf && port_enable |=> overrun_error_flag && !fif.push;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overrun not flagged");

  property p_off;
    @(posedge mclk_i) disable iff (sys_rst_i)
    srst |=> rxdt_oe_n_o && txck_oe_n_o && fif.cnt == 2'h0;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled port still active");

  property p_empty;
    @(posedge mclk_i) disable iff (sys_rst_i)
    t_load && !srst && !(wr && wb_adr_i == OFF_TXDATA)
      |=> tx_st == TX_SHIFT && !tx_full;
  endproperty
  a_empty: assert property (p_empty)
    else $error("transmit load not seen");

  property p_single_receive_enable;
    @(posedge mclk_i) disable iff (sys_rst_i)
    single_receive_enable_done && !(wr && wb_adr_i == OFF_RXCTL) |=> !single_receive_enable;
  endproperty
  a_single_receive_enable: assert property (p_single_receive_enable)
    else $error("single receive not cleared");

  property p_addr;
    @(posedge mclk_i) disable iff (sys_rst_i)
    r_done && !sync && rx_nine && address_detect_enable && !receive_shift_register[8] |-> !fif.push;
  endproperty
  a_addr: assert property (p_addr)
    else $error("non-address character loaded");

  property p_pend;
    @(posedge mclk_i) disable iff (sys_rst_i)
    rx_en && fif.cnt != 2'h0 |=> receive_pending_o;
  endproperty
  a_pend: assert property (p_pend)
    else $error("receive pending missing");

  property p_prio;
    @(posedge mclk_i) disable iff (sys_rst_i)
    rx_sync_en |=> tx_st == TX_IDLE ##1 rxdt_oe_n_o;
  endproperty
  a_prio: assert property (p_prio)
    else $error("transmit ran during sync receive");

  property p_start;
    @(posedge mclk_i) disable iff (sys_rst_i)
    rx_st == RX_START && r_half && dt_s2 && rx_en && !srst
      |=> rx_st == RX_IDLE && !r_done;
  endproperty
  a_start: assert property (p_start)
    else $error("false start not dropped");
endmodule : spc_top

// file: verification/spc_peer.sv
`timescale 1ns/1ps
module spc_peer (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1;

  task automatic send(input logic [8:0] d, input int nb, input int bt,
    input logic stp);
    @(posedge mclk_i);
    line_o <= 1'b0;
    repeat (bt) @(posedge mclk_i);
    for (int i = 0; i < nb; i++) begin
      line_o <= d[i];
      repeat (bt) @(posedge mclk_i);
    end
    line_o <= stp;
    repeat (bt) @(posedge mclk_i);
    line_o <= 1'b1;
  endtask : send

  // Samples data bits and stop bit at bit centres
  task automatic grab(input int nb, input int bt, output logic [9:0] d);
    d = '0;
    @(negedge line_i);
    repeat (bt / 2) @(posedge mclk_i);
    for (int i = 0; i <= nb; i++) begin
      repeat (bt) @(posedge mclk_i);
      d[i] = line_i;
    end
  endtask : grab
endmodule : spc_peer

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import spc_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] rdat;
  logic ack;
  logic rxdt_i;
  logic rxdt_o;
  logic rxdt_oe_n_o;
  logic txck_i;
  logic txck_o;
  logic txck_oe_n_o;
  logic pend;
  logic peer_tx;
  int err_total = 0;
  int n_tests = 0;
  int cyc_cnt = 0;

  // Wire level from both parties
  assign rxdt_i = rxdt_oe_n_o ? peer_tx : rxdt_o;
  assign txck_i = txck_oe_n_o ? 1'b1 : txck_o;

  spc_top u_spc_top (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(4'hF),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .rxdt_i(rxdt_i),
    .rxdt_o(rxdt_o),
    .rxdt_oe_n_o(rxdt_oe_n_o),
    .txck_i(txck_i),
    .txck_o(txck_o),
    .txck_oe_n_o(txck_oe_n_o),
    .receive_pending_o(pend)
  );

  spc_peer u_spc_peer (
    .mclk_i(mclk_i),
    .line_i(txck_o),
    .line_o(peer_tx)
  );

  always #2 mclk_i = ~mclk_i;

  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  always @(posedge mclk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge mclk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk({24'h0, q}, {24'h0, e});
  endtask : rdchk

  task automatic t_regs;
    rdchk(OFF_TXCTL, 8'h02);
    rdchk(OFF_RXCTL, 8'h00);
    rdchk(OFF_BAUD, 8'h00);
    rdchk(8'h18, 8'h00);
    wr(OFF_TXCTL, 8'hFD);
    rdchk(OFF_TXCTL, 8'hF7);
    wr(OFF_BAUD, 8'hA5);
    rdchk(OFF_BAUD, 8'hA5);
    wr(OFF_TXCTL, 8'h00);
    rdchk(OFF_TXCTL, 8'h02);
  endtask : t_regs

  task automatic t_tx(input logic [7:0] tc, input logic [7:0] dv,
    input int nb, input int bt, input logic [9:0] e);
    logic [9:0] got;
    wr(OFF_BAUD, dv);
    wr(OFF_TXCTL, tc);
    wr(OFF_RXCTL, 8'h80);
    repeat (4) @(posedge mclk_i);
    chk(txck_oe_n_o, 1'b0);
    fork
      u_spc_peer.grab(nb, bt, got);
      begin
        wr(OFF_TXDATA, e[7:0]);
        @(negedge txck_o);
        repeat (4) @(posedge mclk_i);
        rdchk(OFF_TXCTL, tc);
      end
    join
    chk(got, e);
    repeat (bt) @(posedge mclk_i);
    rdchk(OFF_TXCTL, tc | 8'h02);
  endtask : t_tx

  task automatic t_rx;
    wr(OFF_BAUD, 8'h01);
    wr(OFF_TXCTL, 8'h04);
    wr(OFF_RXCTL, 8'hD0);
    u_spc_peer.send(9'h1FF, 9, 4, 1'b1);
    repeat (400) @(posedge mclk_i);
    chk(pend, 1'b0);
    u_spc_peer.send(9'h13C, 9, 32, 1'b1);
    repeat (4) @(posedge mclk_i);
    chk(pend, 1'b1);
    rdchk(OFF_STAT, 8'h01);
    rdchk(OFF_RXCTL, 8'hD1);
    rdchk(OFF_RXDATA, 8'h3C);
    u_spc_peer.send(9'h055, 9, 32, 1'b0);
    repeat (4) @(posedge mclk_i);
    rdchk(OFF_RXCTL, 8'hD4);
    rdchk(OFF_RXDATA, 8'h55);
    repeat (4) @(posedge mclk_i);
    chk(pend, 1'b0);
  endtask : t_rx

  task automatic t_ovr;
    wr(OFF_RXCTL, 8'h00);
    wr(OFF_RXCTL, 8'h90);
    u_spc_peer.send(9'h011, 8, 32, 1'b1);
    u_spc_peer.send(9'h022, 8, 32, 1'b1);
    u_spc_peer.send(9'h033, 8, 32, 1'b1);
    repeat (4) @(posedge mclk_i);
    rdchk(OFF_RXCTL, 8'h92);
    rdchk(OFF_RXDATA, 8'h11);
    rdchk(OFF_RXDATA, 8'h22);
    u_spc_peer.send(9'h044, 8, 32, 1'b1);
    repeat (4) @(posedge mclk_i);
    chk(pend, 1'b0);
    wr(OFF_RXCTL, 8'h80);
    rdchk(OFF_RXCTL, 8'h80);
    u_spc_peer.send(9'h055, 8, 32, 1'b1);
    repeat (4) @(posedge mclk_i);
    chk(pend, 1'b0);
    wr(OFF_RXCTL, 8'h90);
    u_spc_peer.send(9'h066, 8, 32, 1'b1);
    repeat (4) @(posedge mclk_i);
    rdchk(OFF_RXDATA, 8'h66);
  endtask : t_ovr

  task automatic t_addr;
    wr(OFF_RXCTL, 8'h00);
    wr(OFF_RXCTL, 8'hD8);
    u_spc_peer.send(9'h0AA, 9, 32, 1'b1);
    repeat (4) @(posedge mclk_i);
    chk(pend, 1'b0);
    u_spc_peer.send(9'h1A7, 9, 32, 1'b1);
    repeat (4) @(posedge mclk_i);
    chk(pend, 1'b1);
    rdchk(OFF_RXDATA, 8'hA7);
  endtask : t_addr

  task automatic t_sync;
    time t0;
    logic [7:0] got;
    wr(OFF_RXCTL, 8'h00);
    wr(OFF_BAUD, 8'h02);
    wr(OFF_TXCTL, 8'h94);
    wr(OFF_RXCTL, 8'h90);
    @(negedge txck_o);
    t0 = $time;
    @(negedge txck_o);
    chk(32'($time - t0), 32'd48);
    chk(txck_oe_n_o, 1'b0);
    wr(OFF_TXCTL, 8'h14);
    repeat (4) @(posedge mclk_i);
    chk(txck_oe_n_o, 1'b1);
    wr(OFF_RXCTL, 8'h00);
    repeat (4) @(posedge mclk_i);
    chk({rxdt_oe_n_o, txck_oe_n_o}, 2'b11);
    // Sync master transmit, data taken on clock rise
    wr(OFF_TXCTL, 8'hB0);
    wr(OFF_RXCTL, 8'h80);
    wr(OFF_TXDATA, 8'hA5);
    for (int i = 0; i < 8; i++) begin
      @(posedge txck_o);
      got[i] = rxdt_o;
    end
    chk(got, 8'hA5);
    chk(rxdt_oe_n_o, 1'b0);
    // Single receive stops after one character
    wr(OFF_TXCTL, 8'h90);
    wr(OFF_RXCTL, 8'hA0);
    repeat (200) @(posedge mclk_i);
    rdchk(OFF_RXCTL, 8'h80);
    rdchk(OFF_RXDATA, 8'hFF);
  endtask : t_sync

  initial begin
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_tx(8'h20, 8'h00, 8, 64, 10'h1A5);
    t_tx(8'h65, 8'h01, 9, 32, 10'h35A);
    t_rx();
    t_ovr();
    t_addr();
    t_sync();
    print_verdict();
  end
endmodule : tb_top
